// ### dv/smtfe_frontend_monitor.sv
// Checker for the front end: fetch, prefetch, dispatch and partition relations.
// Assumes it is bound to the front end and sees only its ports.
module smtfe_frontend_monitor (
	// Clock and reset
	input logic clk,
	input logic rstn,
	// Fetch side
	input logic [3:0] thread_active,
	input logic [255:0] thread_pc,
	input logic icache_req,
	input logic [63:0] icache_addr,
	input logic [1:0] icache_tid,
	input logic icache_hit,
	input logic pf_req,
	input logic [63:0] pf_addr,
	input logic [7:0] bp_valid,
	// Dispatch and status
	input logic [5:0] disp_valid,
	input logic [11:0] disp_tid,
	input logic [5:0] disp_superslice,
	input logic [8:0] ct_size,
	input logic [1:0] mode,
	input logic [3:0] lowpwr,
	input logic [7:0] eff_pri
);
	import smtfe_pkg::*;
	logic [63:0] sel_pc;
	logic [3:0] grp_n;
	logic [7:0] gap_ff;
	logic lp_prev_ff;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Expected group size: the last quadword of a line stops the group early
	assign sel_pc = thread_pc[icache_tid*64 +: 64];
	assign grp_n = (sel_pc[6:4] == 3'h7) ? 4'h4 - {2'h0, sel_pc[3:2]} : 4'h8 - {2'h0, sel_pc[3:2]};
	// Cycles since thread 0 last fetched, saturating so it never wraps to small
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) gap_ff <= 8'h00;
		else if (icache_req && icache_tid == 2'h0) gap_ff <= 8'h00;
		else if (gap_ff != 8'hff) gap_ff <= gap_ff + 8'h01;
	end
	// Thread 0 has made one paced fetch already in this low-power stay
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) lp_prev_ff <= 1'b0;
		else if (!lowpwr[0]) lp_prev_ff <= 1'b0;
		else if (icache_req && icache_tid == 2'h0) lp_prev_ff <= 1'b1;
	end
	a_reset_state: assert property (!$past(rstn) |-> mode == 2'h0 && lowpwr == 4'h0
		&& eff_pri == 8'haa) else $error("state after reset is wrong");
	a_quad_addr: assert property (icache_req |-> icache_addr[3:0] == 4'h0)
		else $error("fetch address not on a quadword");
	a_group_size: assert property (icache_req && icache_hit |=>
		$countones(bp_valid) == $past(grp_n)) else $error("fetch group size wrong");
	a_four_mode: assert property ($countones(thread_active) > 2 |=> mode == 2'h3)
		else $error("four-thread mode not entered");
	a_ct_split: assert property (ct_size == ((mode == 2'h3) ? 9'h040 :
		(mode == 2'h1) ? 9'h080 : 9'h100)) else $error("completion table split wrong");
	a_pf_miss: assert property (icache_req && !icache_hit && mode != 2'h3 |=> pf_req &&
		pf_addr == {$past(icache_addr[63:7]) + 57'h1, 7'h00}) else $error("no prefetch");
	a_pf_four: assert property (mode == 2'h3 && $past(mode) == 2'h3 |-> !pf_req)
		else $error("prefetch in four-thread mode");
	a_split_lanes: assert property (mode == 2'h3 && $past(mode) == 2'h3 |->
		(!disp_valid[0] || (!disp_tid[1] && !disp_superslice[0])) &&
		(!disp_valid[3] || (disp_tid[7] && disp_superslice[3]))) else $error("lane pairing");
	a_paced_fetch: assert property (icache_req && icache_tid == 2'h0 && lowpwr[0] &&
		lp_prev_ff |-> gap_ff >= 8'h7f) else $error("low-power fetch too soon");
	c_four: cover property (mode == 2'h3);
	c_prefetch: cover property (pf_req);
	c_paced: cover property (icache_req && lowpwr[0] && lp_prev_ff);
endmodule : smtfe_frontend_monitor

bind smtfe_frontend smtfe_frontend_monitor mon (.clk, .rstn, .thread_active, .thread_pc,
	.icache_req, .icache_addr, .icache_tid, .icache_hit, .pf_req, .pf_addr, .bp_valid,
	.disp_valid, .disp_tid, .disp_superslice, .ct_size, .mode, .lowpwr, .eff_pri);

// ### dv/smtfe_frontend_tb.sv
// Self-checking bench for the fetch front end, one task per scenario.
// Assumes the cache model answers every fetch in the same cycle.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import smtfe_pkg::*;
	logic clk, rstn, icache_is_target, miss_on, icache_req, icache_hit, pf_req, disp_mem_shared;
	logic [3:0] thread_active, thread_long_stall, thread_flush, thread_is_isync, decode_ready;
	logic [3:0] lowpwr, issue_limit;
	logic [7:0] thread_pri_req, bp_valid, eff_pri;
	logic [255:0] thread_pc, icache_data, bp_insn;
	logic [63:0] icache_addr, pf_addr;
	logic [1:0] icache_tid, mode;
	logic [5:0] disp_valid, disp_superslice;
	logic [191:0] disp_insn;
	logic [11:0] disp_tid;
	logic [31:0] ct_base, hint_addr, hint_word;
	logic [8:0] ct_size;
	int errors, compares;
	smtfe_frontend uut (.clk, .rstn, .thread_active, .thread_pri_req, .thread_long_stall,
		.thread_flush, .thread_is_isync, .thread_pc, .icache_req, .icache_addr, .icache_tid,
		.icache_hit, .icache_data, .icache_is_target, .pf_req, .pf_addr, .bp_valid, .bp_insn,
		.decode_ready, .disp_valid, .disp_insn, .disp_tid, .disp_superslice, .disp_mem_shared,
		.issue_limit, .ct_base, .ct_size, .mode, .lowpwr, .eff_pri);
	smtfe_icache_model cache (.icache_req, .icache_addr, .miss_on, .hint_addr, .hint_word,
		.icache_hit, .icache_data);
	// Core clock, 20 ns period
	always #10 clk = ~clk;
	task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// Empty thread 0's buffer, then point it at a new address
	task refetch(input logic [63:0] pc);
		thread_flush = 4'h1;
		cyc(1);
		thread_flush = 4'h0;
		thread_pc[63:0] = pc;
	endtask : refetch
	task close_out;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task t_reset;
		chk("mode", 0, mode);
		chk("lowpwr", 0, lowpwr);
		chk("eff_pri", 8'haa, eff_pri);
		chk("bp_valid", 0, bp_valid);
	endtask : t_reset
	// Four quadword offsets, then the four offsets of a line's last quadword
	task t_groups;
		logic [63:0] pc;
		for (int k = 0; k < 8; k++) begin
			pc = (k < 4) ? 64'h1000 + 64'(4 * k) : 64'h1070 + 64'(4 * (k - 4));
			refetch(pc);
			#1 chk("icache_addr", {pc[63:4], 4'h0}, icache_addr);
			cyc(1);
			chk("group size", 64'(8 - k), 64'($countones(bp_valid)));
			chk("first word", {32'h0, pc[31:0]}, {32'h0, bp_insn[31:0]});
		end
	endtask : t_groups
	task t_full;
		refetch(64'h1000);
		cyc(10);
		chk("fetch when full", 0, icache_req);
		decode_ready = 4'h1;
		cyc(1);
		chk("dispatch lanes", 6'h3f, disp_valid);
		chk("dispatch thread", 0, disp_tid);
		chk("dispatch word", 64'h1000, {32'h0, disp_insn[31:0]});
	endtask : t_full
	task t_pf;
		miss_on = 1'b1;
		thread_pc[63:0] = 64'h1140;
		cyc(4);
		chk("prefetch", 1, pf_req);
		chk("prefetch addr", 64'h1180, pf_addr);
		miss_on = 1'b0;
	endtask : t_pf
	task t_lowpwr;
		int n;
		n = 0;
		thread_pri_req[1:0] = 2'h0;
		cyc(4);
		chk("low power on", 1, lowpwr[0]);
		repeat (256) begin
			cyc(1);
			n += int'(icache_req);
		end
		chk("paced fetches", 2, n);
		thread_pri_req[1:0] = 2'h2;
		cyc(4);
		chk("low power off", 0, lowpwr[0]);
	endtask : t_lowpwr
	task t_hint;
		hint_addr = 32'h00003000;
		hint_word = OR_R31_HINT;
		thread_pc[63:0] = 64'h3000;
		cyc(6);
		hint_addr = 32'hffffffff;
		thread_flush = 4'h1;
		thread_is_isync = 4'h1;
		cyc(1);
		thread_flush = 4'h0;
		thread_is_isync = 4'h0;
		cyc(4);
		chk("isync low power", 1, lowpwr[0]);
		hint_addr = 32'h00003000;
		hint_word = OR_R2_HINT;
		for (int i = 0; i < 300 && lowpwr[0]; i++) cyc(1);
		chk("normal again", 0, lowpwr[0]);
		chk("priority back", 2, eff_pri[1:0]);
		hint_addr = 32'hffffffff;
	endtask : t_hint
	task t_rr;
		logic [1:0] last;
		thread_active = 4'h3;
		decode_ready = 4'h0;
		thread_pc[127:64] = 64'h2000;
		thread_flush = 4'h3;
		cyc(1);
		thread_flush = 4'h0;
		chk("two threads", 1, mode);
		chk("ct size two", 9'h080, ct_size);
		#1 last = icache_tid;
		for (int i = 0; i < 3; i++) begin
			cyc(1);
			chk("turn taking", {1'b0, ~last[0]}, icache_tid);
			last = icache_tid;
		end
		// A high request must win the first slot after both buffers empty
		thread_pri_req[3:2] = 2'h3;
		cyc(1);
		thread_flush = 4'h3;
		cyc(1);
		thread_flush = 4'h0;
		#1 chk("high first", 1, icache_tid);
		thread_long_stall = 4'h2;
		cyc(2);
		chk("stall lowers", 1, eff_pri[3:2]);
		chk("stall yields", 0, icache_tid);
		thread_long_stall = 4'h0;
		thread_pri_req = 8'haa;
	endtask : t_rr
	task t_four;
		// Decode held off so every buffer holds at least three before dispatch opens
		thread_active = 4'hf;
		thread_pc[255:128] = {64'h5000, 64'h4000};
		cyc(12);
		chk("four threads", 3, mode);
		chk("ct size four", 9'h040, ct_size);
		chk("ct base", 32'hc0804000, ct_base);
		chk("issue width", 9, issue_limit);
		chk("shared memory", 1, disp_mem_shared);
		decode_ready = 4'hf;
		cyc(1);
		chk("both pipes", 6'h3f, disp_valid);
		chk("pipe threads", 12'ha80, disp_tid);
		chk("own superslice", 6'h38, disp_superslice);
		chk("second pipe word", 64'h4000, {32'h0, disp_insn[127:96]});
		miss_on = 1'b1;
		cyc(4);
		chk("no prefetch", 0, pf_req);
		miss_on = 1'b0;
	endtask : t_four
	// Main sequence: reset for eight cycles, then every scenario in turn
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		icache_is_target = 1'b0;
		miss_on = 1'b0;
		thread_active = 4'h1;
		thread_long_stall = 4'h0;
		thread_flush = 4'h0;
		thread_is_isync = 4'h0;
		decode_ready = 4'h0;
		thread_pri_req = 8'haa;
		thread_pc = '0;
		hint_addr = 32'hffffffff;
		hint_word = 32'h00000000;
		errors = 0;
		compares = 0;
		cyc(8);
		rstn = 1'b1;
		t_reset;
		t_groups;
		t_full;
		t_pf;
		t_lowpwr;
		t_hint;
		t_rr;
		t_four;
		close_out;
	end
	// Watchdog: the scenarios need at most about 640 cycles
	initial begin
		#100us;
		errors++;
		$display("watchdog expired");
		close_out;
	end
endmodule : testbench

// ### dv/smtfe_icache_model.sv
// Instruction cache model facing the front end's fetch port.
// Assumes quadword-aligned requests that want a same-cycle answer.
module smtfe_icache_model (
	// Request from the front end
	input logic icache_req,
	input logic [63:0] icache_addr,
	// Bench controls: forced miss and one planted instruction word
	input logic miss_on,
	input logic [31:0] hint_addr,
	input logic [31:0] hint_word,
	// Answer
	output logic icache_hit,
	output logic [255:0] icache_data
);
	logic [31:0] word;
	// Eight words from the quadword on
	always_comb begin
		icache_hit = icache_req && !miss_on;
		for (int i = 0; i < 8; i++) begin
			word = icache_addr[31:0] + 32'(4 * i);
			// Without a hit the inverse shows, so stale words never look valid
			icache_data[i*32 +: 32] = !icache_hit ? ~word : (word == hint_addr) ? hint_word : word;
		end
	end
endmodule : smtfe_icache_model

// ### src/smtfe_frontend.sv
// Multi-thread instruction fetch front end: fetch selection, buffering, decode.
// Assumes the instruction cache answers in the same cycle with a 32-byte window.
// Summary of operation
// - Fetch up to eight four-byte instructions each cycle from the cache.
// - Run branch prediction on every valid instruction of the fetch group.
// - Prefetcher requests the next line after a cache miss, except in four-thread mode.
// - Eight-wide writes into the buffer, or up to six bypass into decode.
// - Round-robin fetch among threads; a full buffer stops that thread.
// - Honour thread priority; long stalls lower a thread's priority.
// - Very low priority: one fetch of up to eight every 128 cycles.
// - OR r31 requests low power, entered without isync once no further OR r31 is fetched; OR r2 restores normal.
// - Cache accessed at any quadword, returns up to 32 bytes per cycle.
// - Branch target fetch yields five to eight by quadword alignment.
// - A fetch never crosses a 128-byte line; it is truncated there.
// - Decode and dispatch up to six operations per cycle in total.
// - Issue up to nine operations per cycle to execution.
// - Single, two and four thread modes, up to four threads.
// - Over two threads: four-thread mode, one three-wide pipe per thread pair.
// - Split pipes feed own superslice; branch and memory slices stay shared.
// - Completion table split in two or four equal partitions.
module smtfe_frontend (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Thread control
	input wire logic [smtfe_pkg::NUM_THREADS-1:0] thread_active,
	input wire logic [smtfe_pkg::NUM_THREADS*2-1:0] thread_pri_req,
	input wire logic [smtfe_pkg::NUM_THREADS-1:0] thread_long_stall,
	input wire logic [smtfe_pkg::NUM_THREADS-1:0] thread_flush,
	input wire logic [smtfe_pkg::NUM_THREADS-1:0] thread_is_isync,
	input wire logic [smtfe_pkg::NUM_THREADS*64-1:0] thread_pc,
	// Instruction cache request and answer
	output logic icache_req,
	output logic [63:0] icache_addr,
	output logic [smtfe_pkg::TID_W-1:0] icache_tid,
	input wire logic icache_hit,
	input wire logic [smtfe_pkg::CACHE_RETURN_BYTES*8-1:0] icache_data,
	input wire logic icache_is_target,
	// Prefetch request
	output logic pf_req,
	output logic [63:0] pf_addr,
	// Branch prediction hook
	output logic [smtfe_pkg::FETCH_WIDTH-1:0] bp_valid,
	output logic [smtfe_pkg::FETCH_WIDTH*32-1:0] bp_insn,
	// Decode / dispatch
	input wire logic [smtfe_pkg::NUM_THREADS-1:0] decode_ready,
	output logic [smtfe_pkg::DISPATCH_WIDTH-1:0] disp_valid,
	output logic [smtfe_pkg::DISPATCH_WIDTH*32-1:0] disp_insn,
	output logic [smtfe_pkg::DISPATCH_WIDTH*2-1:0] disp_tid,
	output logic [smtfe_pkg::DISPATCH_WIDTH-1:0] disp_superslice,
	output logic disp_mem_shared,
	// Issue limit and completion table partition
	output logic [3:0] issue_limit,
	output logic [smtfe_pkg::NUM_THREADS*smtfe_pkg::CT_IDX_W-1:0] ct_base,
	output logic [smtfe_pkg::CT_IDX_W:0] ct_size,
	// Status
	output logic [1:0] mode,
	output logic [smtfe_pkg::NUM_THREADS-1:0] lowpwr,
	output logic [smtfe_pkg::NUM_THREADS*2-1:0] eff_pri
);
	import smtfe_pkg::*;

	smtfe_mode_t mode_ff;
	smtfe_mode_t nxt_mode;
	logic [TID_W-1:0] rr_ff;
	logic [NUM_THREADS-1:0] lp_req_ff;
	logic [NUM_THREADS-1:0] lp_ff;
	logic [LOWPWR_CNT_W-1:0] lp_cnt_ff [NUM_THREADS];
	smtfe_pri_t pri_ff [NUM_THREADS];
	logic [NUM_THREADS-1:0] buf_full;
	logic [BUF_CNT_W-1:0] buf_level [NUM_THREADS];
	logic [BUF_CNT_W-1:0] buf_space [NUM_THREADS];
	logic [BYPASS_WIDTH*32-1:0] buf_rd [NUM_THREADS];
	logic [3:0] wr_cnt [NUM_THREADS];
	logic [2:0] rd_cnt [NUM_THREADS];
	logic [NUM_THREADS-1:0] eligible;
	logic sel_ok;
	logic [TID_W-1:0] sel_tid;
	logic [63:0] sel_pc;
	logic [3:0] grp_cnt;
	logic [2:0] nact;
	logic [DISPATCH_WIDTH-1:0] nxt_dvalid;
	logic [DISPATCH_WIDTH*32-1:0] nxt_dinsn;
	logic [DISPATCH_WIDTH*2-1:0] nxt_dtid;
	logic [DISPATCH_WIDTH-1:0] nxt_dss;
	logic [DISPATCH_WIDTH-1:0] disp_valid_ff;
	logic [DISPATCH_WIDTH*32-1:0] disp_insn_ff;
	logic [DISPATCH_WIDTH*2-1:0] disp_tid_ff;
	logic [DISPATCH_WIDTH-1:0] disp_ss_ff;
	logic [FETCH_WIDTH-1:0] bp_valid_ff;
	logic [FETCH_WIDTH*32-1:0] bp_insn_ff;
	logic pf_req_ff;
	logic [63:0] pf_addr_ff;

	// Active thread count picks the mode
	always_comb begin
		nact = '0;
		for (int t = 0; t < NUM_THREADS; t++) begin
			nact = 3'(nact + 3'(thread_active[t]));
		end
		if (nact > 3'd2) nxt_mode = SMTFE_FOUR;
		else if (nact == 3'd2) nxt_mode = SMTFE_TWO;
		else nxt_mode = SMTFE_SINGLE;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) mode_ff <= RESET_MODE;
		else mode_ff <= nxt_mode;
	end

	// Priority and low-power state per thread
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lp_req_ff <= '0;
			lp_ff <= '0;
			for (int t = 0; t < NUM_THREADS; t++) begin
				pri_ff[t] <= RESET_PRI;
				lp_cnt_ff[t] <= '0;
			end
		end else begin
			for (int t = 0; t < NUM_THREADS; t++) begin
				if (thread_long_stall[t]) pri_ff[t] <= SMTFE_PRI_LOW;
				else pri_ff[t] <= smtfe_pri_t'(thread_pri_req[t*2 +: 2]);
				if (sel_ok && sel_tid == TID_W'(t) && icache_data[31:0] == OR_R2_HINT) begin
					lp_req_ff[t] <= 1'b0;
					lp_ff[t] <= 1'b0;
				end else if (sel_ok && sel_tid == TID_W'(t) && icache_data[31:0] == OR_R31_HINT) begin
					lp_req_ff[t] <= 1'b1;
				end else if (thread_is_isync[t] && thread_flush[t] && lp_req_ff[t]) begin
					lp_ff[t] <= 1'b1;
				end else begin
					lp_ff[t] <= lp_req_ff[t] | (thread_pri_req[t*2 +: 2] == SMTFE_PRI_VLOW);
				end
				if (!lp_ff[t]) lp_cnt_ff[t] <= '0;
				else lp_cnt_ff[t] <= LOWPWR_CNT_W'(lp_cnt_ff[t] + 1'b1);
			end
		end
	end

	// Eligibility: active, buffer not full, pacing slot reached
	always_comb begin
		for (int t = 0; t < NUM_THREADS; t++) begin
			eligible[t] = thread_active[t] && !buf_full[t]
				&& (!lp_ff[t] || lp_cnt_ff[t] == '0);
		end
	end

	// Round-robin pick, higher priority first
	always_comb begin
		logic [TID_W-1:0] idx;
		logic [1:0] best;
		idx = '0;
		best = '0;
		sel_ok = 1'b0;
		sel_tid = '0;
		for (int k = 0; k < NUM_THREADS; k++) begin
			idx = TID_W'(rr_ff + TID_W'(k));
			if (eligible[idx] && (!sel_ok || pri_ff[idx] > best)) begin
				sel_ok = 1'b1;
				sel_tid = idx;
				best = pri_ff[idx];
			end
		end
		sel_pc = thread_pc[sel_tid*64 +: 64];
	end

	// Rotation pointer advances past the thread just fetched
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) rr_ff <= '0;
		else if (sel_ok) rr_ff <= TID_W'(sel_tid + 1'b1);
	end

	assign icache_req = sel_ok;
	assign icache_addr = {sel_pc[63:4], 4'h0};
	assign icache_tid = sel_tid;

	// Group size: from the quadword offset to 32 bytes, clipped at line end
	always_comb begin
		logic [5:0] to_line;
		logic [3:0] base;
		base = 4'(FETCH_WIDTH) - {2'h0, sel_pc[3:2]};
		// Words left in the line; six bits so a whole line of 32 does not wrap to zero
		to_line = 6'(INSN_PER_LINE) - {1'b0, sel_pc[6:2]};
		if ({2'h0, base} > to_line) grp_cnt = 4'(to_line);
		else grp_cnt = base;
		if (!sel_ok || !icache_hit) grp_cnt = 4'h0;
	end

	// Per-thread buffers: one instance per thread
	for (genvar t = 0; t < NUM_THREADS; t++) begin : g_buf
		smtfe_thread_buf u_buf (
			.clk(clk),
			.rstn(rstn),
			.wr_cnt(wr_cnt[t]),
			.wr_data(icache_data >> (sel_pc[3:2] * 32)),
			.rd_cnt(rd_cnt[t]),
			.rd_data(buf_rd[t]),
			.level(buf_level[t]),
			.full(buf_full[t]),
			.space(buf_space[t]),
			.flush(thread_flush[t])
		);
	end

	// Dispatch slots: six shared, or three per thread pair in four-thread mode
	always_comb begin
		int slot;
		int lane;
		logic [2:0] take;
		logic [2:0] cap;
		slot = 0;
		lane = 0;
		take = 3'h0;
		cap = 3'h0;
		nxt_dvalid = '0;
		nxt_dinsn = '0;
		nxt_dtid = '0;
		nxt_dss = '0;
		for (int t = 0; t < NUM_THREADS; t++) begin
			rd_cnt[t] = '0;
			wr_cnt[t] = (sel_tid == TID_W'(t)) ? grp_cnt : 4'h0;
		end
		for (int t = 0; t < NUM_THREADS; t++) begin
			lane = (mode_ff == SMTFE_FOUR) ? (t / 2) * SPLIT_WIDTH : slot;
			cap = (mode_ff == SMTFE_FOUR) ? 3'(SPLIT_WIDTH - (lane % SPLIT_WIDTH))
				: 3'(DISPATCH_WIDTH - slot);
			if (mode_ff == SMTFE_FOUR && nxt_dvalid[lane]) cap = 3'h0;
			take = (buf_level[t] > BUF_CNT_W'(cap)) ? cap : 3'(buf_level[t]);
			if (!decode_ready[t] || thread_flush[t]) take = 3'h0;
			rd_cnt[t] = take;
			for (int i = 0; i < BYPASS_WIDTH; i++) begin
				if (3'(i) < take) begin
					nxt_dvalid[lane + i] = 1'b1;
					nxt_dinsn[(lane + i)*32 +: 32] = buf_rd[t][i*32 +: 32];
					nxt_dtid[(lane + i)*2 +: 2] = 2'(t);
					nxt_dss[lane + i] = (mode_ff == SMTFE_FOUR) ? 1'(t / 2) : 1'(lane + i >= 3);
				end
			end
			if (mode_ff != SMTFE_FOUR) slot = slot + int'(take);
		end
	end

	// Registered dispatch group; the buffer path stands in for bypass latency
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			disp_valid_ff <= '0;
			disp_insn_ff <= '0;
			disp_tid_ff <= '0;
			disp_ss_ff <= '0;
		end else begin
			disp_valid_ff <= nxt_dvalid;
			disp_insn_ff <= nxt_dinsn;
			disp_tid_ff <= nxt_dtid;
			disp_ss_ff <= nxt_dss;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bp_valid_ff <= '0;
			bp_insn_ff <= '0;
		end else begin
			for (int i = 0; i < FETCH_WIDTH; i++) bp_valid_ff[i] <= 4'(i) < grp_cnt;
			bp_insn_ff <= icache_data >> (sel_pc[3:2] * 32);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pf_req_ff <= 1'b0;
			pf_addr_ff <= '0;
		end else begin
			pf_req_ff <= sel_ok && !icache_hit && mode_ff != SMTFE_FOUR;
			pf_addr_ff <= {sel_pc[63:7], 7'h0} + 64'(LINE_BYTES);
		end
	end

	always_comb begin
		unique case (mode_ff)
			SMTFE_SINGLE: ct_size = (CT_IDX_W+1)'(CT_ENTRIES);
			SMTFE_TWO: ct_size = (CT_IDX_W+1)'(CT_ENTRIES / 2);
			SMTFE_FOUR: ct_size = (CT_IDX_W+1)'(CT_ENTRIES / 4);
			default: ct_size = (CT_IDX_W+1)'(CT_ENTRIES);
		endcase
		for (int t = 0; t < NUM_THREADS; t++) begin
			ct_base[t*CT_IDX_W +: CT_IDX_W] = (mode_ff == SMTFE_SINGLE) ? '0
				: CT_IDX_W'(ct_size * ((CT_IDX_W+1)'(t) % (mode_ff == SMTFE_TWO ? 2 : 4)));
		end
	end

	assign issue_limit = 4'(ISSUE_WIDTH);
	assign disp_mem_shared = 1'b1;
	assign disp_valid = disp_valid_ff;
	assign disp_insn = disp_insn_ff;
	assign disp_tid = disp_tid_ff;
	assign disp_superslice = disp_ss_ff;
	assign bp_valid = bp_valid_ff;
	assign bp_insn = bp_insn_ff;
	assign pf_req = pf_req_ff;
	assign pf_addr = pf_addr_ff;
	assign mode = mode_ff;
	assign lowpwr = lp_ff;
	always_comb begin
		for (int t = 0; t < NUM_THREADS; t++) eff_pri[t*2 +: 2] = pri_ff[t];
	end
endmodule : smtfe_frontend

// ### src/smtfe_pkg.sv
// Shared constants and types for the multi-thread instruction fetch front end.
// Assumes a single core clock and an active-low asynchronous reset.
package smtfe_pkg;
	// Instruction and cache geometry
	localparam int INSN_BYTES = 4;
	localparam int FETCH_WIDTH = 8;
	localparam int QUAD_BYTES = 16;
	localparam int CACHE_RETURN_BYTES = 32;
	localparam int LINE_BYTES = 128;
	localparam int INSN_PER_QUAD = QUAD_BYTES / INSN_BYTES;
	localparam int INSN_PER_LINE = LINE_BYTES / INSN_BYTES;
	// Stage bandwidths
	localparam int BYPASS_WIDTH = 6;
	localparam int DISPATCH_WIDTH = 6;
	localparam int SPLIT_WIDTH = 3;
	localparam int ISSUE_WIDTH = 9;
	// Threads
	localparam int NUM_THREADS = 4;
	localparam int TID_W = 2;
	// Low-power pacing interval in cycles
	localparam int LOWPWR_INTERVAL = 128;
	localparam int LOWPWR_CNT_W = 7;
	// Fetch buffer depth per thread, in instructions
	localparam int BUF_DEPTH = 32;
	localparam int BUF_CNT_W = 6;
	// Completion table entries
	localparam int CT_ENTRIES = 256;
	localparam int CT_IDX_W = 8;
	// Special no-op priority hints: OR rX,rX,rX encodings
	localparam logic [31:0] OR_R31_HINT = 32'h7ffffb78;
	localparam logic [31:0] OR_R2_HINT = 32'h7c421378;
	// Priority levels
	typedef enum logic [1:0] {
		SMTFE_PRI_VLOW = 2'h0,
		SMTFE_PRI_LOW = 2'h1,
		SMTFE_PRI_NORMAL = 2'h2,
		SMTFE_PRI_HIGH = 2'h3
	} smtfe_pri_t;
	// Thread modes (Gray along single, two, four)
	typedef enum logic [1:0] {
		SMTFE_SINGLE = 2'h0,
		SMTFE_TWO = 2'h1,
		SMTFE_FOUR = 2'h3
	} smtfe_mode_t;
	localparam smtfe_pri_t RESET_PRI = SMTFE_PRI_NORMAL;
	localparam smtfe_mode_t RESET_MODE = SMTFE_SINGLE;
endpackage : smtfe_pkg

// ### src/smtfe_thread_buf.sv
// One thread's fetch instruction buffer: takes up to eight, gives up to six.
// Assumes the caller never writes more than the free space it is told about.
module smtfe_thread_buf #(
	parameter int DEPTH = smtfe_pkg::BUF_DEPTH,
	parameter int CNT_W = smtfe_pkg::BUF_CNT_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Write side
	input wire logic [3:0] wr_cnt,
	input wire logic [smtfe_pkg::FETCH_WIDTH*32-1:0] wr_data,
	// Read side
	input wire logic [2:0] rd_cnt,
	output logic [smtfe_pkg::BYPASS_WIDTH*32-1:0] rd_data,
	// Occupancy
	output logic [CNT_W-1:0] level,
	output logic full,
	output logic [CNT_W-1:0] space,
	// Flush
	input wire logic flush
);
	import smtfe_pkg::*;

	localparam int PTR_W = $clog2(DEPTH);

	logic [31:0] mem_ff [DEPTH];
	logic [PTR_W-1:0] wr_ptr_ff;
	logic [PTR_W-1:0] rd_ptr_ff;
	logic [CNT_W-1:0] cnt_ff;

	// Space reported counts a full eight-wide group; a short group never overflows
	assign level = cnt_ff;
	assign space = CNT_W'(DEPTH) - cnt_ff;
	assign full = (space < CNT_W'(FETCH_WIDTH));

	// Storage writes
	always_ff @(posedge clk) begin
		for (int i = 0; i < FETCH_WIDTH; i++) begin
			if (4'(i) < wr_cnt) begin
				mem_ff[PTR_W'(wr_ptr_ff + PTR_W'(i))] <= wr_data[i*32 +: 32];
			end
		end
	end

	// Read data is the oldest six words
	always_comb begin
		for (int i = 0; i < BYPASS_WIDTH; i++) begin
			rd_data[i*32 +: 32] = mem_ff[PTR_W'(rd_ptr_ff + PTR_W'(i))];
		end
	end

	// Pointers and count
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
		end else if (flush) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ptr_ff <= PTR_W'(wr_ptr_ff + PTR_W'(wr_cnt));
			rd_ptr_ff <= PTR_W'(rd_ptr_ff + PTR_W'(rd_cnt));
			cnt_ff <= CNT_W'(cnt_ff + CNT_W'(wr_cnt) - CNT_W'(rd_cnt));
		end
	end
endmodule : smtfe_thread_buf
